// ===== rtl/ssi_pkg.sv
// shared constants and types of the synchronous serial shifter
package ssi_pkg;
	localparam int DATA_W = 8;
	localparam int CNT_W = 3;
	localparam int AXI_AW = 8;
	localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;
	localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;

	// register indices; byte address is four times the index
	localparam logic [11:0] SMR_IDX = 12'h005;
	localparam logic [11:0] SRL_IDX = 12'h006;
	localparam logic [11:0] SRU_IDX = 12'h007;
	localparam logic [11:0] PORT_MODE_REG_A_IDX = 12'h008;
	localparam logic [11:0] CMD_IDX = 12'h009;
	localparam logic [11:0] STAT_IDX = 12'h00A;
	localparam logic [11:0] PORT_IDX = 12'h00B;

	localparam logic [3:0] SMR_RESET = 4'h0;
	localparam logic [1:0] PORT_MODE_REG_A_RESET = 2'h0;
	localparam int SMR_PIN_BIT = 3;
	localparam logic [2:0] CLK_SYS = 3'h6;
	localparam logic [2:0] CLK_EXT = 3'h7;
	localparam int CMD_START_BIT = 0;
	localparam int STAT_IRQ_BIT = 0;
	localparam int STAT_ST_LSB = 1;
	localparam int STAT_CNT_LSB = 3;
	localparam int STAT_SCK_BIT = 6;
	localparam int PORT_OUT_BIT = 0;
	localparam int PORT_OE_BIT = 1;
	localparam int PORT_IN_BIT = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// timing: aclk cycles per instruction cycle, mode write latency
	localparam int CLK_HZ = 20000000;
	localparam int TCYC_CLKS = 2;
	localparam int SMR_VALID_TCYC = 2;
	localparam int SMR_DELAY_CLKS = SMR_VALID_TCYC * TCYC_CLKS;

	typedef enum logic [1:0] {
		ST_START_WAIT = 2'b00,
		ST_CLK_WAIT = 2'b01,
		ST_XFER = 2'b10
	} ser_state_t;

	typedef enum logic [1:0] {
		MODE_CONT = 2'b00,
		MODE_TX = 2'b01,
		MODE_RX = 2'b10,
		MODE_TXRX = 2'b11
	} op_mode_t;

	function automatic logic [AXI_AW-1:0] reg_addr(input logic [11:0] idx);
		reg_addr = {idx[AXI_AW-3:0], 2'b00};
	endfunction
endpackage

// ===== rtl/shift_clk_gen.sv
// prescaler that paces the internal shift clock half periods
`timescale 1ns/1ps
module shift_clk_gen import ssi_pkg::*; #(
	parameter int TCYC = TCYC_CLKS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic [2:0] src,
	output logic tick
);
	localparam int CW = 14;
	localparam int unsigned RATIO [0:5] = '{2048, 512, 128, 32, 8, 2};

	logic [CW-1:0] cnt_q;

	// half period in aclk cycles, minus one
	function automatic logic [CW-1:0] half_m1(input logic [2:0] code);
		int unsigned h;
		h = 1;
		if (code == CLK_SYS)
			h = (TCYC > 1) ? TCYC / 2 : 1;
		else if (code < CLK_SYS)
			h = RATIO[code] * TCYC;
		half_m1 = CW'(h - 1);
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn)
			cnt_q <= '0;
		else if (!run || src == CLK_EXT || cnt_q == '0)
			cnt_q <= half_m1(src);
		else
			cnt_q <= cnt_q - CW'(1);
	end

	assign tick = run && src != CLK_EXT && cnt_q == '0;
endmodule

// ===== rtl/sync_serial_8bit_shifter.sv
// clock-synchronous 8-bit serial shifter with AXI4-Lite registers
//
// Overview of operation
// - moves 8-bit units over a clocked serial link, both directions
// - start clears the 3-bit counter; counting from falling, steps on rising
// - flag set on the eighth clock or when a transfer is aborted
// - mode write reinitialises, gates clock; mid-transfer aborts, sets flag
// - mode write acts two instruction cycles later; start waits that long, but the logic acts on start at once
// - mode register clears to zero at reset
// - mode bits 2..0 pick prescaler ratio, system clock or external clock
// - output changes on falling edge, input sampled on rising, LSB first
// - 8-bit data register, read and write as two nibbles
// - port mode bits 1..0 pick continuous clock, transmit, receive or both
// - start-wait ignores clocks; start moves to clock-wait
// - clock in clock-wait shifts, enters transfer; continuous mode no shift
// - eight clocks or start end the transfer, clear counter, set flag
// - internal clock driven after start, stops after the eighth clock except in continuous mode
// - port mode write while busy needs a mode write, back to start-wait
// - extra clocks cycle transfer, clock-wait, transfer again
// - flag cleared before a mode write stays cleared
`timescale 1ns/1ps
module sync_serial_8bit_shifter import ssi_pkg::*; #(
	parameter int TCYC = TCYC_CLKS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [AXI_AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [AXI_AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic si,
	output logic so,
	input wire logic shared_port_pin_i,
	output logic shared_port_pin_o,
	output logic shared_port_pin_oe,
	output logic serial_irq
);
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic aw_hold_q, w_hold_q;
	logic [AXI_AW-1:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic [3:0] smr_q, smr_pend_q;
	logic [2:0] smr_dly_q;
	logic [1:0] port_mode_reg_a_q;
	op_mode_t mode_q;
	logic port_out_q, port_oe_q;
	ser_state_t state_q;
	logic [CNT_W-1:0] cnt_q;
	logic [DATA_W-1:0] shift_data_reg_q;
	logic irq_q, so_q, sck_q, sck_prev_q, run_q;
	logic pin_o_q, pin_oe_q;
	logic wr_do, wr_hit, smr_wr, srl_wr, sru_wr, port_mode_reg_a_wr, start, flag_clr;
	logic port_wr, smr_apply, tick, ext_src, fall_ev, rise_ev, cont;
	logic last_rise, irq_set;
	logic [31:0] rd_mux;
	logic rd_hit;

	function automatic logic at(input logic [AXI_AW-1:0] a,
			input logic [11:0] idx);
		at = (a == reg_addr(idx));
	endfunction

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign so = so_q;
	assign serial_irq = irq_q;
	assign shared_port_pin_o = pin_o_q;
	assign shared_port_pin_oe = pin_oe_q;

	// write channel: address and data taken in either order
	assign wr_do = aw_hold_q && w_hold_q && !bvalid_q;
	assign wr_hit = at(awaddr_q, SMR_IDX) || at(awaddr_q, SRL_IDX) ||
		at(awaddr_q, SRU_IDX) || at(awaddr_q, PORT_MODE_REG_A_IDX) ||
		at(awaddr_q, CMD_IDX) || at(awaddr_q, STAT_IDX) ||
		at(awaddr_q, PORT_IDX);
	assign smr_wr = wr_do && wstrb_q[0] && at(awaddr_q, SMR_IDX);
	assign srl_wr = wr_do && wstrb_q[0] && at(awaddr_q, SRL_IDX);
	assign sru_wr = wr_do && wstrb_q[0] && at(awaddr_q, SRU_IDX);
	assign port_mode_reg_a_wr = wr_do && wstrb_q[0] && at(awaddr_q, PORT_MODE_REG_A_IDX);
	assign port_wr = wr_do && wstrb_q[0] && at(awaddr_q, PORT_IDX);
	assign start = wr_do && wstrb_q[0] && at(awaddr_q, CMD_IDX) &&
		wdata_q[CMD_START_BIT];
	assign flag_clr = wr_do && wstrb_q[0] && at(awaddr_q, STAT_IDX) &&
		wdata_q[STAT_IRQ_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'h1;
			wready_q <= 1'h1;
			aw_hold_q <= 1'h0;
			w_hold_q <= 1'h0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid_q <= 1'h0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (awvalid && awready_q) begin
				aw_hold_q <= 1'h1;
				awready_q <= 1'h0;
				awaddr_q <= awaddr;
			end
			if (wvalid && wready_q) begin
				w_hold_q <= 1'h1;
				wready_q <= 1'h0;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (wr_do) begin
				aw_hold_q <= 1'h0;
				w_hold_q <= 1'h0;
				bvalid_q <= 1'h1;
				bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_q && bready) begin
				bvalid_q <= 1'h0;
				awready_q <= 1'h1;
				wready_q <= 1'h1;
			end
		end
	end

	// read mux; the mode register is write-only and reads zero
	always_comb begin
		rd_mux = '0;
		rd_hit = 1'h1;
		if (at(araddr, SMR_IDX) || at(araddr, CMD_IDX))
			rd_mux = '0;
		else if (at(araddr, SRL_IDX))
			rd_mux[3:0] = shift_data_reg_q[3:0];
		else if (at(araddr, SRU_IDX))
			rd_mux[3:0] = shift_data_reg_q[7:4];
		else if (at(araddr, PORT_MODE_REG_A_IDX))
			rd_mux[1:0] = port_mode_reg_a_q;
		else if (at(araddr, STAT_IDX)) begin
			rd_mux[STAT_IRQ_BIT] = irq_q;
			rd_mux[STAT_ST_LSB +: 2] = state_q;
			rd_mux[STAT_CNT_LSB +: CNT_W] = cnt_q;
			rd_mux[STAT_SCK_BIT] = shared_port_pin_i;
		end else if (at(araddr, PORT_IDX)) begin
			rd_mux[PORT_OUT_BIT] = port_out_q;
			rd_mux[PORT_OE_BIT] = port_oe_q;
			rd_mux[PORT_IN_BIT] = shared_port_pin_i;
		end else
			rd_hit = 1'h0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'h1;
			rvalid_q <= 1'h0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (arvalid && arready_q) begin
			arready_q <= 1'h0;
			rvalid_q <= 1'h1;
			rdata_q <= rd_mux;
			rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'h0;
			arready_q <= 1'h1;
		end
	end

	// mode write lands after the settling delay
	assign smr_apply = (smr_dly_q == 3'h1);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			smr_q <= SMR_RESET;
			smr_pend_q <= SMR_RESET;
			smr_dly_q <= '0;
			mode_q <= MODE_CONT;
		end else begin
			if (smr_wr) begin
				smr_pend_q <= wdata_q[3:0];
				smr_dly_q <= 3'(SMR_DELAY_CLKS);
			end else if (smr_dly_q != '0)
				smr_dly_q <= smr_dly_q - 3'h1;
			// operating mode latched only by a mode write
			if (smr_apply) begin
				smr_q <= smr_pend_q;
				mode_q <= op_mode_t'(port_mode_reg_a_q);
			end
		end
	end

	// port mode stored; takes hold at the next mode write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_mode_reg_a_q <= PORT_MODE_REG_A_RESET;
			port_out_q <= 1'h0;
			port_oe_q <= 1'h0;
		end else begin
			if (port_mode_reg_a_wr)
				port_mode_reg_a_q <= wdata_q[1:0];
			if (port_wr) begin
				port_out_q <= wdata_q[PORT_OUT_BIT];
				port_oe_q <= wdata_q[PORT_OE_BIT];
			end
		end
	end

	shift_clk_gen #(.TCYC(TCYC)) u_clk_gen (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(run_q),
		.src(smr_q[2:0]),
		.tick(tick)
	);

	// external clock edges come from the pin
	assign ext_src = (smr_q[2:0] == CLK_EXT);
	assign fall_ev = smr_q[SMR_PIN_BIT] && (ext_src ?
		(sck_prev_q && !shared_port_pin_i) : (tick && sck_q));
	assign rise_ev = smr_q[SMR_PIN_BIT] && (ext_src ?
		(!sck_prev_q && shared_port_pin_i) : (tick && !sck_q));
	assign cont = (mode_q == MODE_CONT);
	assign last_rise = rise_ev && state_q == ST_XFER && cnt_q == CNT_LAST &&
		!cont;

	// internal clock runs from start to the eighth clock, or until a mode write in continuous mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_q <= 1'h0;
			sck_q <= 1'h1;
			sck_prev_q <= 1'h1;
		end else begin
			sck_prev_q <= shared_port_pin_i;
			if (smr_wr) begin
				// clock gated off by a mode write
				run_q <= 1'h0;
				sck_q <= 1'h1;
			end else if (start) begin
				run_q <= smr_q[SMR_PIN_BIT] && !ext_src;
				sck_q <= 1'h1;
			end else begin
				if (tick)
					sck_q <= !sck_q;
				if (last_rise)
					run_q <= 1'h0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_START_WAIT;
			cnt_q <= CNT_ZERO;
		end else if (smr_wr) begin
			state_q <= ST_START_WAIT;
			cnt_q <= CNT_ZERO;
		end else if (start) begin
			state_q <= ST_CLK_WAIT;
			cnt_q <= CNT_ZERO;
		end else if (!cont) begin
			case (state_q)
				ST_CLK_WAIT: begin
					if (fall_ev)
						state_q <= ST_XFER;
				end
				ST_XFER: begin
					// eighth rising edge ends the transfer
					if (last_rise) begin
						state_q <= ST_CLK_WAIT;
						cnt_q <= CNT_ZERO;
					end else if (rise_ev)
						cnt_q <= cnt_q + 3'h1;
				end
				default: begin
					state_q <= state_q;
				end
			endcase
		end
	end

	// output on falling edge, sample on rising, LSB first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_data_reg_q <= '0;
			so_q <= 1'h1;
		end else if (srl_wr || sru_wr) begin
			// nibble access to the data register
			if (srl_wr)
				shift_data_reg_q[3:0] <= wdata_q[3:0];
			if (sru_wr)
				shift_data_reg_q[7:4] <= wdata_q[3:0];
		end else if (smr_wr) begin
			// initialised output idles high
			so_q <= 1'h1;
		end else if (state_q != ST_START_WAIT && !cont && !start)
				begin
			if (fall_ev && mode_q[0])
				so_q <= shift_data_reg_q[0];
			// eight bits shift through per transfer
			if (rise_ev && state_q == ST_XFER)
				shift_data_reg_q <= {mode_q[1] ? si : 1'h0,
					shift_data_reg_q[DATA_W-1:1]};
		end
	end

	// flag set on completion or abort
	assign irq_set = last_rise || ((smr_wr || start) && state_q == ST_XFER);
	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_q <= 1'h0;
		else if (irq_set)
			irq_q <= 1'h1;
		else if (flag_clr)
			irq_q <= 1'h0;
	end

	// shared pin is port or serial clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_o_q <= 1'h1;
			pin_oe_q <= 1'h0;
		end else if (smr_q[SMR_PIN_BIT]) begin
			pin_o_q <= sck_q;
			// external clock leaves the pin undriven
			pin_oe_q <= !ext_src;
		end else begin
			pin_o_q <= port_out_q;
			pin_oe_q <= port_oe_q;
		end
	end

	property p_smr_reset;
		@(posedge aclk) disable iff (!aresetn)
		$rose(aresetn) |-> smr_q == SMR_RESET && !irq_q;
	endproperty
	a_smr_reset: assert property (p_smr_reset)
		else $error("mode register not zero after reset");

	property p_start_clr;
		@(posedge aclk) disable iff (!aresetn)
		start && !smr_wr |=> cnt_q == CNT_ZERO && state_q == ST_CLK_WAIT;
	endproperty
	a_start_clr: assert property (p_start_clr)
		else $error("start did not clear the counter");

	property p_eighth;
		@(posedge aclk) disable iff (!aresetn)
		last_rise && !smr_wr && !start |=>
			irq_q && state_q == ST_CLK_WAIT && cnt_q == CNT_ZERO;
	endproperty
	a_eighth: assert property (p_eighth)
		else $error("eighth clock did not end the transfer");

	property p_abort;
		@(posedge aclk) disable iff (!aresetn)
		smr_wr && state_q == ST_XFER |=>
			irq_q && state_q == ST_START_WAIT && cnt_q == CNT_ZERO && !run_q;
	endproperty
	a_abort: assert property (p_abort)
		else $error("mode write did not abort the transfer");

	property p_smr_late;
		@(posedge aclk) disable iff (!aresetn)
		smr_wr |=> smr_q == $past(smr_q) ##1 smr_q == $past(smr_q, 2);
	endproperty
	a_smr_late: assert property (p_smr_late)
		else $error("mode write took effect too early");

	property p_wait_idle;
		@(posedge aclk) disable iff (!aresetn)
		state_q == ST_START_WAIT && !start |=>
			state_q != ST_XFER && cnt_q == CNT_ZERO;
	endproperty
	a_wait_idle: assert property (p_wait_idle)
		else $error("start-wait reacted to a clock");

	property p_ext_hiz;
		@(posedge aclk) disable iff (!aresetn)
		pin_oe_q |-> !($past(smr_q[SMR_PIN_BIT]) &&
			$past(smr_q[2:0]) == CLK_EXT);
	endproperty
	a_ext_hiz: assert property (p_ext_hiz)
		else $error("clock pin driven with external source");

	property p_so_fall;
		@(posedge aclk) disable iff (!aresetn)
		$changed(so_q) |-> $past(fall_ev) || $past(smr_wr);
	endproperty
	a_so_fall: assert property (p_so_fall)
		else $error("serial output changed off a falling edge");

	property p_sticky;
		@(posedge aclk) disable iff (!aresetn)
		irq_q && !flag_clr |=> irq_q;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("flag dropped without a clear");

	property p_set_wins;
		@(posedge aclk) disable iff (!aresetn)
		irq_set && flag_clr |=> irq_q;
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("clear beat a concurrent set");

	c_done: cover property (@(posedge aclk) disable iff (!aresetn)
		last_rise ##1 irq_q);
	c_abort: cover property (@(posedge aclk) disable iff (!aresetn)
		smr_wr && state_q == ST_XFER);
	c_ext: cover property (@(posedge aclk) disable iff (!aresetn)
		ext_src && last_rise);
	c_restart: cover property (@(posedge aclk) disable iff (!aresetn)
		start && state_q == ST_XFER);
endmodule

// ===== testbench/peer_ctrl.sv
// far-side controller model on the clocked serial link
`timescale 1ns/1ps
module peer_ctrl (
	input wire logic sck,
	input wire logic so,
	input wire logic [7:0] tx_byte,
	output logic si,
	output logic clk_o,
	output logic clk_oe,
	output logic [7:0] rx_byte
);
	int n;
	initial begin
		si = 1'b1;
		clk_o = 1'b1;
		clk_oe = 1'b0;
		rx_byte = 8'h00;
		n = 0;
	end
	always @(negedge sck) begin
		si <= (n < 8) ? tx_byte[n[2:0]] : ~si;
	end
	always @(posedge sck) begin
		rx_byte <= {so, rx_byte[7:1]};
		n <= n + 1;
	end
	task automatic restart();
		n = 0;
	endtask
	// slow external clock, released between bursts
	task automatic burst(input int cnt, input int half);
		clk_oe = 1'b1;
		repeat (cnt) begin
			#half clk_o = 1'b0;
			#half clk_o = 1'b1;
		end
		clk_oe = 1'b0;
	endtask
endmodule

// ===== testbench/tb.sv
// self-checking bench of the synchronous serial shifter
`timescale 1ns/1ps
module tb import ssi_pkg::*;;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [AXI_AW-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic awready, wready, bvalid, arready, rvalid, so, si;
	logic [1:0] bresp, rresp;
	logic pin_o, pin_oe, serial_irq, p_o, p_oe, ext_on, oe_bad, so_bad;
	logic [7:0] tx_byte, rx_byte;
	wire pin;
	int miscompares, tests_run;
	int rt[6] = '{2048, 512, 128, 32, 8, 2};
	// pulled up when nobody drives
	assign pin = pin_oe ? pin_o : (p_oe ? p_o : 1'b1);
	sync_serial_8bit_shifter #(.TCYC(TCYC_CLKS)) dut (.aclk, .aresetn,
		.awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .si, .so, .shared_port_pin_i(pin),
		.shared_port_pin_o(pin_o), .shared_port_pin_oe(pin_oe),
		.serial_irq);
	peer_ctrl peer (.sck(pin), .so, .tx_byte, .si, .clk_o(p_o),
		.clk_oe(p_oe), .rx_byte);
	always @(posedge aclk) begin
		if (ext_on && pin_oe !== 1'b0) oe_bad <= 1'b1;
		if (ext_on && so !== 1'b1) so_bad <= 1'b1;
	end
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	function automatic logic [7:0] ad(input logic [11:0] i);
		return {i[5:0], 2'b00};
	endfunction
	task automatic wr(input logic [11:0] i, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY);
		@(posedge aclk);
		awaddr <= ad(i);
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask
	task automatic rchk(input string nm, input logic [11:0] i,
		input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
		@(posedge aclk);
		araddr <= ad(i);
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rready <= 1'b0;
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		chk(nm, e, (i == STAT_IDX) ? {26'h0, rdata[5:0]} : rdata);
	endtask
	task automatic mode(input logic [3:0] m);
		wr(SMR_IDX, {28'h0, m});
		repeat (SMR_DELAY_CLKS) @(posedge aclk);
	endtask
	task automatic wait_pin(input logic v, input int lim, output int k);
		k = 0;
		while (pin_o !== v && k < lim) begin
			@(posedge aclk);
			k++;
		end
	endtask
	task automatic wait_irq(input int lim);
		int k;
		k = 0;
		while (serial_irq !== 1'b1 && k < lim) begin
			@(posedge aclk);
			k++;
		end
	endtask
	task automatic s_reset();
		chk("irq", 0, serial_irq);
		chk("pin_oe", 0, pin_oe);
		chk("so", 1, so);
		rchk("status", STAT_IDX, 0);
	endtask
	task automatic s_regs();
		wr(SRL_IDX, 32'h5);
		wr(SRU_IDX, 32'hA);
		rchk("low", SRL_IDX, 32'h5);
		rchk("high", SRU_IDX, 32'hA);
		wr(12'h03F, 32'h1, RESP_SLVERR);
		rchk("unmapped", 12'h03F, 32'h0, RESP_SLVERR);
		wr(PORT_IDX, 32'h3);
		@(posedge aclk);
		chk("port oe", 1, pin_oe);
		wr(PORT_IDX, 32'h2);
		@(posedge aclk);
		chk("port out", 0, pin_o);
		wr(PORT_IDX, 32'h0);
	endtask
	task automatic s_rate();
		int k, n, e;
		wr(PORT_MODE_REG_A_IDX, 32'h0);
		for (int c = 0; c < 7; c++) begin
			mode(4'h8 | c[3:0]);
			wr(CMD_IDX, 32'h1);
			wait_pin(1'b0, 10000, k);
			wait_pin(1'b1, 10000, n);
			e = (c < 6) ? rt[c] * TCYC_CLKS : TCYC_CLKS / 2;
			chk("half period", e, n);
			chk("clk oe", 1, pin_oe);
		end
		rchk("status", STAT_IDX, 32'h02);
		chk("irq", 0, serial_irq);
	endtask
	task automatic s_xfer();
		wr(PORT_MODE_REG_A_IDX, 32'h3);
		mode(4'hD);
		tx_byte <= 8'h3C;
		peer.restart();
		wr(CMD_IDX, 32'h1);
		wait_irq(400);
		chk("irq", 1, serial_irq);
		// data read only after the transfer
		rchk("low", SRL_IDX, 32'hC);
		chk("peer rx", 32'hA5, rx_byte);
		rchk("high", SRU_IDX, 32'h3);
		rchk("status", STAT_IDX, 32'h03);
		repeat (40) @(posedge aclk);
		chk("clock stopped", 1, pin_o);
		wr(STAT_IDX, 32'h1);
		chk("irq cleared", 0, serial_irq);
		mode(4'hD);
		chk("irq kept", 0, serial_irq);
	endtask
	task automatic s_abort(input bit by_start);
		int k;
		mode(4'hC);
		wr(CMD_IDX, 32'h1);
		wait_pin(1'b0, 200, k);
		wait_pin(1'b1, 200, k);
		@(posedge aclk);
		if (by_start) wr(CMD_IDX, 32'h1);
		else wr(SMR_IDX, 32'hC);
		chk("abort irq", 1, serial_irq);
		rchk("status", STAT_IDX, by_start ? 32'h03 : 32'h01);
		mode(4'hC);
		wr(STAT_IDX, 32'h1);
	endtask
	task automatic s_ext();
		wr(PORT_MODE_REG_A_IDX, 32'h2);
		mode(4'hF);
		ext_on <= 1'b1;
		peer.burst(3, 133);
		rchk("status", STAT_IDX, 32'h00);
		tx_byte <= 8'h96;
		peer.restart();
		wr(CMD_IDX, 32'h1);
		peer.burst(8, 133);
		wait_irq(20);
		chk("irq", 1, serial_irq);
		rchk("low", SRL_IDX, 32'h6);
		rchk("high", SRU_IDX, 32'h9);
		peer.burst(9, 133);
		repeat (4) @(posedge aclk);
		rchk("status", STAT_IDX, 32'h0D);
		ext_on <= 1'b0;
		chk("ext oe", 0, oe_bad);
		chk("rx so idle", 0, so_bad);
	endtask
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, tx_byte} = '0;
		wstrb = 4'hF;
		{ext_on, oe_bad, so_bad} = '0;
		miscompares = 0;
		tests_run = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		s_reset();
		s_regs();
		s_rate();
		s_xfer();
		s_abort(1'b0);
		s_abort(1'b1);
		s_ext();
		end_of_test();
	end
	initial begin
		repeat (100000) @(posedge aclk);
		miscompares++;
		end_of_test();
	end
endmodule
